// *** rtl/drgc_gate_control.sv ***
// Read-in enable gate for the distortion analyzer with Avalon-MM control registers
`timescale 1ns/100ps
`default_nettype none
`include "drgc_defs.svh"

module drgc_gate_control
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      srst,
    // Avalon-MM slave
    input  wire logic [3:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    // Time base, baud distributor, sampler and comparator
    input  wire logic [`DRGC_COUNT_W-1:0]  time_base_count,
    input  wire logic                      char_sync_exclusion,
    input  wire logic                      transition_window_in,
    input  wire logic                      mark_to_space_pulse,
    input  wire logic                      space_to_mark_pulse,
    input  wire logic                      store_below_count,
    // Storage register and early/late logic
    output logic                           capture_enable,
    output logic                           readin_enable_gate_n,
    output logic                           early_selection_gate,
    output logic                           late_selection_gate,
    // Configuration toward sampler and baud distributor
    output logic      [1:0]                measure_type_select,
    output logic                           polarity_select,
    output logic      [2:0]                transition_number_select
);

    drgc_pkg::drgc_mode_t mode;
    drgc_pkg::drgc_pol_t  polarity;
    logic                 count_half_select_bit;
    logic                 early_window_qualifier;
    logic                 late_window_qualifier;
    logic                 selected_transition_window;
    logic                 comparison_qualifier;
    logic                 sampled_transition_pulse;
    logic                 qual_all;
    logic                 next_capture_enable;
    logic                 next_readin_enable_gate_n;
    logic                 next_early_selection_gate;
    logic                 next_late_selection_gate;
    logic [31:0]          next_avs_readdata;
    logic                 next_avs_waitrequest;
    logic [1:0]           next_measure_type_select;
    logic                 next_polarity_select;
    logic [2:0]           next_transition_number_select;
    logic [15:0]          capt_count;
    logic [15:0]          next_capt_count;
    logic [31:0]          status_word;
    drgc_pkg::drgc_reg_t  sel;

    assign mode     = drgc_pkg::drgc_mode_t'(measure_type_select);
    assign polarity = drgc_pkg::drgc_pol_t'(polarity_select);

    // Count spans 0 to COUNTS_PER_BIT-1; top bit splits the bit in halves
    assign count_half_select_bit = (time_base_count < `DRGC_HALF_COUNT);

    drgc_window_qual u_window_qual
    (
        .mode                   (mode),
        .count_half_select_bit  (count_half_select_bit),
        .early_window_qualifier (early_window_qualifier),
        .late_window_qualifier  (late_window_qualifier)
    );

    drgc_pulse_select u_pulse_select
    (
        .mode                     (mode),
        .polarity                 (polarity),
        .mark_to_space_pulse      (mark_to_space_pulse),
        .space_to_mark_pulse      (space_to_mark_pulse),
        .sampled_transition_pulse (sampled_transition_pulse)
    );

    assign selected_transition_window = (transition_number_select == `DRGC_XSEL_ALL)
                                        | transition_window_in;
    assign comparison_qualifier = (mode == drgc_pkg::drgc_average) | store_below_count;

    // Six-input coincidence gate
    assign qual_all = early_window_qualifier
                    & late_window_qualifier
                    & char_sync_exclusion
                    & selected_transition_window
                    & sampled_transition_pulse
                    & comparison_qualifier;

    function automatic drgc_pkg::drgc_reg_t reg_sel(input logic [3:0] addr);
        case (addr)
            `DRGC_CTRL_OFS:   reg_sel = drgc_pkg::drgc_reg_ctrl;
            `DRGC_STATUS_OFS: reg_sel = drgc_pkg::drgc_reg_status;
            `DRGC_CAPT_OFS:   reg_sel = drgc_pkg::drgc_reg_capt;
            default:          reg_sel = drgc_pkg::drgc_reg_none;
        endcase
    endfunction

    assign sel = reg_sel(avs_address);

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[`DRGC_STAT_EN_BIT]    = capture_enable;
        status_word[`DRGC_STAT_EARLY_BIT] = early_window_qualifier;
        status_word[`DRGC_STAT_LATE_BIT]  = late_window_qualifier;
        status_word[`DRGC_STAT_CMP_BIT]   = comparison_qualifier;
    end

    // Gate outputs: registered one clock after the qualifiers line up
    always_comb
    begin
        next_capture_enable       = qual_all;
        next_readin_enable_gate_n = !qual_all;
        next_early_selection_gate = qual_all & !count_half_select_bit;
        next_late_selection_gate  = qual_all & count_half_select_bit;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            capture_enable       <= 1'b0;
            readin_enable_gate_n <= 1'b1;
            early_selection_gate <= 1'b0;
            late_selection_gate  <= 1'b0;
        end
        else
        begin
            capture_enable       <= next_capture_enable;
            readin_enable_gate_n <= next_readin_enable_gate_n;
            early_selection_gate <= next_early_selection_gate;
            late_selection_gate  <= next_late_selection_gate;
        end
    end

    // Bus slave: every access answers on the second edge after it is raised
    always_comb
    begin
        next_avs_waitrequest          = 1'b1;
        next_avs_readdata             = avs_readdata;
        next_measure_type_select      = measure_type_select;
        next_polarity_select          = polarity_select;
        next_transition_number_select = transition_number_select;
        next_capt_count               = capt_count;
        if ((avs_read | avs_write) && avs_waitrequest)
        begin
            next_avs_waitrequest = 1'b0;
        end
        if (avs_read && avs_waitrequest)
        begin
            unique case (sel)
                drgc_pkg::drgc_reg_ctrl:
                begin
                    next_avs_readdata = {26'h0000000, transition_number_select,
                                         polarity_select, measure_type_select};
                end
                drgc_pkg::drgc_reg_status: next_avs_readdata = status_word;
                drgc_pkg::drgc_reg_capt:   next_avs_readdata = {16'h0000, capt_count};
                drgc_pkg::drgc_reg_none:   next_avs_readdata = 32'h0000_0000;
            endcase
        end
        if (avs_write && !avs_waitrequest && avs_byteenable[0])
        begin
            // Mode is meant to be set while idle; a change mid-character spoils one reading
            if (sel == drgc_pkg::drgc_reg_ctrl)
            begin
                next_measure_type_select      = avs_writedata[`DRGC_MODE_MSB:`DRGC_MODE_LSB];
                next_polarity_select          = avs_writedata[`DRGC_POL_BIT];
                next_transition_number_select = avs_writedata[`DRGC_XSEL_MSB:`DRGC_XSEL_LSB];
            end
            if (sel == drgc_pkg::drgc_reg_capt)
            begin
                next_capt_count = `DRGC_CAPT_RESET;
            end
        end
        // An enable in the clearing cycle still counts
        if (capture_enable)
        begin
            next_capt_count = next_capt_count + 16'h0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            avs_waitrequest          <= 1'b1;
            avs_readdata             <= 32'h0000_0000;
            measure_type_select      <= `DRGC_MODE_RESET;
            polarity_select          <= `DRGC_POL_RESET;
            transition_number_select <= `DRGC_XSEL_RESET;
            capt_count               <= `DRGC_CAPT_RESET;
        end
        else
        begin
            avs_waitrequest          <= next_avs_waitrequest;
            avs_readdata             <= next_avs_readdata;
            measure_type_select      <= next_measure_type_select;
            polarity_select          <= next_polarity_select;
            transition_number_select <= next_transition_number_select;
            capt_count               <= next_capt_count;
        end
    end

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (srst);

    a_avg_windows_pass:
    assert property ((mode == drgc_pkg::drgc_average || mode == drgc_pkg::drgc_total_peak)
                     |-> early_window_qualifier && late_window_qualifier)
        else $error("window qualifier low in average or total peak");

    a_early_lower_block:
    assert property ((mode == drgc_pkg::drgc_early_peak && time_base_count <= `DRGC_HALF_LAST)
                     |-> !early_window_qualifier)
        else $error("early qualifier passes in lower half");

    a_early_late_hold:
    assert property ((mode == drgc_pkg::drgc_early_peak)
                     |-> late_window_qualifier && (early_window_qualifier == time_base_count[6]))
        else $error("early peak window qualifiers wrong");

    a_late_upper_block:
    assert property ((mode == drgc_pkg::drgc_late_peak && time_base_count >= `DRGC_HALF_COUNT)
                     |-> !late_window_qualifier)
        else $error("late qualifier passes in upper half");

    a_late_early_hold:
    assert property ((mode == drgc_pkg::drgc_late_peak)
                     |-> early_window_qualifier && (late_window_qualifier == !time_base_count[6]))
        else $error("late peak window qualifiers wrong");

    a_readin_all_high:
    assert property (capture_enable |-> $past(early_window_qualifier && late_window_qualifier
                     && char_sync_exclusion && selected_transition_window
                     && sampled_transition_pulse && comparison_qualifier))
        else $error("enable without all six qualifiers");

    a_readin_on_all:
    assert property (qual_all |=> capture_enable && !readin_enable_gate_n)
        else $error("all qualifiers high but no enable");

    a_inverted_fanout:
    assert property (capture_enable |-> !readin_enable_gate_n
                     && (early_selection_gate != late_selection_gate))
        else $error("inverted enable or selection gates wrong");

    a_sync_exclusion:
    assert property (!char_sync_exclusion |=> !capture_enable && readin_enable_gate_n)
        else $error("enable during character sync exclusion");

    a_all_window_high:
    assert property ((transition_number_select == `DRGC_XSEL_ALL) |-> selected_transition_window)
        else $error("selected window low with all transitions");

    a_avg_compare_high:
    assert property ((mode == drgc_pkg::drgc_average) |-> comparison_qualifier)
        else $error("comparison qualifier low in average mode");

    a_peak_compare_gate:
    assert property ((mode != drgc_pkg::drgc_average && !store_below_count)
                     |=> !capture_enable)
        else $error("peak enable without store below count");

    a_avg_polarity:
    assert property (($past(mode) == drgc_pkg::drgc_average && capture_enable)
                     |-> $past(polarity_select ? space_to_mark_pulse : mark_to_space_pulse))
        else $error("average enable on wrong polarity");

    a_total_coincide:
    assert property (($past(mode) == drgc_pkg::drgc_total_peak && capture_enable)
                     |-> $past((mark_to_space_pulse || space_to_mark_pulse) && store_below_count))
        else $error("total peak enable without coincidence");

    a_early_coincide:
    assert property (($past(mode) == drgc_pkg::drgc_early_peak && capture_enable)
                     |-> $past(time_base_count[6] && store_below_count && sampled_transition_pulse))
        else $error("early peak enable without coincidence");

    a_late_coincide:
    assert property (($past(mode) == drgc_pkg::drgc_late_peak && capture_enable)
                     |-> $past(!time_base_count[6] && store_below_count && sampled_transition_pulse))
        else $error("late peak enable without coincidence");

    a_half_boundary:
    assert property (($past(time_base_count) == `DRGC_HALF_LAST && time_base_count == `DRGC_HALF_COUNT)
                     |-> $past(count_half_select_bit) && !count_half_select_bit)
        else $error("half select bit wrong at count 64");

    a_bus_answer:
    assert property (((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");

    c_avg_enable: cover property (mode == drgc_pkg::drgc_average && capture_enable);
    c_total_enable: cover property (mode == drgc_pkg::drgc_total_peak && capture_enable);
    c_early_enable: cover property (mode == drgc_pkg::drgc_early_peak && early_selection_gate);
    c_late_enable: cover property (mode == drgc_pkg::drgc_late_peak && late_selection_gate);

endmodule

`default_nettype wire

// *** rtl/drgc_pulse_select.sv ***
// Selects the sampled-transition pulse by mode and polarity
`timescale 1ns/100ps
`default_nettype none

module drgc_pulse_select
(
    // Configuration
    input  var  drgc_pkg::drgc_mode_t mode,
    input  var  drgc_pkg::drgc_pol_t  polarity,
    // Synchronised transition pulses
    input  wire logic                 mark_to_space_pulse,
    input  wire logic                 space_to_mark_pulse,
    // Result
    output logic                      sampled_transition_pulse
);

    always_comb
    begin
        if (mode == drgc_pkg::drgc_total_peak)
        begin
            sampled_transition_pulse = mark_to_space_pulse | space_to_mark_pulse;
        end
        else if (polarity == drgc_pkg::drgc_space_to_mark)
        begin
            sampled_transition_pulse = space_to_mark_pulse;
        end
        else
        begin
            sampled_transition_pulse = mark_to_space_pulse;
        end
    end

endmodule

`default_nettype wire

// *** rtl/drgc_window_qual.sv ***
// Early and late window qualifiers from measurement mode and count half
`timescale 1ns/100ps
`default_nettype none

module drgc_window_qual
(
    // Configuration and time base
    input  var  drgc_pkg::drgc_mode_t mode,
    input  wire logic                 count_half_select_bit,
    // Qualifiers
    output logic                      early_window_qualifier,
    output logic                      late_window_qualifier
);

    always_comb
    begin
        early_window_qualifier = 1'b1;
        late_window_qualifier  = 1'b1;
        unique case (mode)
            drgc_pkg::drgc_average,
            drgc_pkg::drgc_total_peak:
            begin
                early_window_qualifier = 1'b1;
                late_window_qualifier  = 1'b1;
            end
            drgc_pkg::drgc_early_peak:
            begin
                // Pass only in the half bit before the ideal transition
                early_window_qualifier = !count_half_select_bit;
                late_window_qualifier  = 1'b1;
            end
            drgc_pkg::drgc_late_peak:
            begin
                early_window_qualifier = 1'b1;
                late_window_qualifier  = count_half_select_bit;
            end
        endcase
    end

endmodule

`default_nettype wire

// *** shared/drgc_defs.svh ***
// Offsets, field positions, reset values and timing counts of the read-in gate control
`ifndef DRGC_DEFS_SVH
`define DRGC_DEFS_SVH

// Register byte offsets
`define DRGC_CTRL_OFS       4'h0
`define DRGC_STATUS_OFS     4'h4
`define DRGC_CAPT_OFS       4'h8

// Control register fields
`define DRGC_MODE_LSB       0
`define DRGC_MODE_MSB       1
`define DRGC_POL_BIT        2
`define DRGC_XSEL_LSB       3
`define DRGC_XSEL_MSB       5

// Status register fields
`define DRGC_STAT_EN_BIT    0
`define DRGC_STAT_EARLY_BIT 1
`define DRGC_STAT_LATE_BIT  2
`define DRGC_STAT_CMP_BIT   3

// Reset values
`define DRGC_MODE_RESET     2'h0
`define DRGC_POL_RESET      1'h0
`define DRGC_XSEL_RESET     3'h0
`define DRGC_CAPT_RESET     16'h0000

// Transition selection code for all transitions
`define DRGC_XSEL_ALL       3'h0

// Time base: timing pulses per bit and first count of the upper half
`define DRGC_COUNTS_PER_BIT 128
`define DRGC_COUNT_W        7
`define DRGC_HALF_COUNT     7'h40
`define DRGC_HALF_LAST      7'h3f

`endif

// *** shared/drgc_pkg.sv ***
// Types shared by the read-in gate control modules
package drgc_pkg;

    typedef enum logic [1:0]
    {
        drgc_average,
        drgc_total_peak,
        drgc_early_peak,
        drgc_late_peak
    } drgc_mode_t;

    typedef enum logic
    {
        drgc_mark_to_space,
        drgc_space_to_mark
    } drgc_pol_t;

    typedef enum logic [1:0]
    {
        drgc_reg_ctrl,
        drgc_reg_status,
        drgc_reg_capt,
        drgc_reg_none
    } drgc_reg_t;

endpackage

// *** tb/distortion_readin_gate_control_tb_top.sv ***
// Self-checking bench for the read-in gate control
`timescale 1ns/100ps
`default_nettype none

module distortion_readin_gate_control_tb_top;
    typedef struct
    {
        logic [1:0] mode;
        logic       pol;
        logic [2:0] xsel;
        logic [6:0] cnt;
        logic       cs, tw, ms, sm, en;
    } drgc_row_t;

    logic        clk, srst, run, load, clr, csync, twin, m2s, s2m;
    logic        avs_read, avs_write, avs_waitrequest, store_below, cap_en, gate_n, e_sel, l_sel, pol_sel;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [6:0]  cnt, load_value;
    logic [1:0]  mode_sel;
    logic [2:0]  xsel_sel;
    int          err_count, checks, cyc, ce_n, es_n, ls_n;
    // mode pol xsel cnt csync twin m2s s2m, then the expected enable
    drgc_row_t rows[13] = '{
        '{2'h0, 1'b0, 3'h0, 7'h0a, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1},
        '{2'h0, 1'b1, 3'h0, 7'h0a, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0},
        '{2'h0, 1'b1, 3'h0, 7'h00, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
        '{2'h0, 1'b0, 3'h0, 7'h0a, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0},
        '{2'h0, 1'b0, 3'h1, 7'h0a, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
        '{2'h1, 1'b0, 3'h0, 7'h14, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
        '{2'h1, 1'b0, 3'h0, 7'h00, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0},
        '{2'h2, 1'b0, 3'h0, 7'h3f, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0},
        '{2'h2, 1'b0, 3'h2, 7'h40, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1},
        '{2'h3, 1'b1, 3'h0, 7'h3f, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
        '{2'h3, 1'b1, 3'h0, 7'h40, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0},
        '{2'h3, 1'b0, 3'h0, 7'h05, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0},
        '{2'h1, 1'b1, 3'h0, 7'h7f, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1}};

    drgc_gate_control dut_u (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .time_base_count(cnt),
        .char_sync_exclusion(csync), .transition_window_in(twin), .mark_to_space_pulse(m2s),
        .space_to_mark_pulse(s2m), .store_below_count(store_below), .capture_enable(cap_en),
        .readin_enable_gate_n(gate_n), .early_selection_gate(e_sel), .late_selection_gate(l_sel),
        .measure_type_select(mode_sel), .polarity_select(pol_sel), .transition_number_select(xsel_sel));

    drgc_far_model far_u (.clk(clk), .srst(srst), .run(run), .load(load), .load_value(load_value), .clr(clr),
        .capture_enable(cap_en), .time_base_count(cnt), .store_below_count(store_below));

    task give_verdict();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low
    task bus(input logic rd, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be, output logic [31:0] q);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= rd;
        avs_write <= !rd;
        n = 0;
        do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++n < 20);
        chk(avs_waitrequest, 1'b0, "bus answer");
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task run_row(input drgc_row_t r);
        logic ew, lw, cm;
        ew = (r.mode != 2'h2) || r.cnt[6];
        lw = (r.mode != 2'h3) || !r.cnt[6];
        cm = (r.mode == 2'h0) || (r.cnt != 7'h00);
        bus(1'b0, 4'h0, {26'h0, r.xsel, r.pol, r.mode}, 4'hf, d);
        @(posedge clk);
        load <= 1'b1; load_value <= r.cnt; clr <= 1'b1; csync <= r.cs; twin <= r.tw;
        @(posedge clk);
        load <= 1'b0; clr <= 1'b0;
        bus(1'b1, 4'h4, 32'h0, 4'hf, d);
        chk(d[3:0], {cm, lw, ew, 1'b0}, "status qualifiers");
        chk({xsel_sel, pol_sel, mode_sel}, {r.xsel, r.pol, r.mode}, "config out");
        @(posedge clk);
        m2s <= r.ms; s2m <= r.sm;
        @(posedge clk);
        @(negedge clk);
        chk(cap_en, r.en, "capture enable");
        chk(gate_n, !r.en, "inverted enable");
        chk({e_sel, l_sel}, {r.en & r.cnt[6], r.en & !r.cnt[6]}, "selection gates");
        @(posedge clk);
        m2s <= 1'b0; s2m <= 1'b0;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            give_verdict();
        end
    end

    initial
    begin
        {srst, run, load, clr, csync, twin, m2s, s2m} = 8'h80;
        {avs_read, avs_write, avs_address, avs_byteenable, avs_writedata, load_value} = '0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk({cap_en, gate_n, avs_waitrequest}, 3'h3, "reset outputs");
        chk(avs_readdata, 32'h0, "reset read data");
        chk({mode_sel, pol_sel, xsel_sel}, 6'h00, "reset config");
        @(posedge clk);
        srst <= 1'b0;
        bus(1'b1, 4'h8, 32'h0, 4'hf, d);
        chk(d, 32'h0, "capture count reset");
        bus(1'b0, 4'hc, 32'hffffffff, 4'hf, d);
        bus(1'b1, 4'hc, 32'h0, 4'hf, d);
        chk(d, 32'h0, "unmapped read");
        bus(1'b0, 4'h0, 32'h3f, 4'h0, d);
        bus(1'b1, 4'h0, 32'h0, 4'hf, d);
        chk(d, 32'h0, "write without byte enable");
        foreach (rows[i])
            run_row(rows[i]);
        // Free run in average mode: every count qualifies
        bus(1'b0, 4'h0, 32'h0, 4'hf, d);
        @(posedge clk);
        csync <= 1'b1; m2s <= 1'b1; run <= 1'b1;
        repeat (3) @(posedge clk);
        repeat (128)
        begin
            @(negedge clk);
            ce_n += cap_en;
            es_n += e_sel;
            ls_n += l_sel;
        end
        chk(ce_n, 128, "free run enables");
        chk({es_n[15:0], ls_n[15:0]}, {16'd64, 16'd64}, "half split");
        @(posedge clk);
        m2s <= 1'b0; run <= 1'b0;
        repeat (2) @(posedge clk);
        bus(1'b0, 4'h8, 32'h0, 4'hf, d);
        @(posedge clk);
        m2s <= 1'b1;
        @(posedge clk);
        m2s <= 1'b0;
        repeat (2) @(posedge clk);
        bus(1'b1, 4'h8, 32'h0, 4'hf, d);
        chk(d, 32'h1, "single pulse count");
        give_verdict();
    end
endmodule
`default_nettype wire

// *** tb/drgc_far_model.sv ***
// Time base counter and storage register comparator facing the read-in gate
`timescale 1ns/100ps
`default_nettype none

module drgc_far_model
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Bench control
    input  wire logic       run,
    input  wire logic       load,
    input  wire logic [6:0] load_value,
    input  wire logic       clr,
    // Gate side
    input  wire logic       capture_enable,
    output logic      [6:0] time_base_count,
    output logic            store_below_count
);
    logic [6:0] store;

    always_ff @(posedge clk)
    begin
        if (srst || clr)
            store <= 7'h00;
        else if (capture_enable)
            store <= time_base_count;
        if (srst)
            time_base_count <= 7'h00;
        else if (load)
            time_base_count <= load_value;
        else if (run)
            time_base_count <= time_base_count + 7'h01;
    end

    // Wraps 127 to 0, so one bit spans 128 counts
    assign store_below_count = store < time_base_count;
endmodule
`default_nettype wire
